// >>> pcrh_core.sv
// Functional notes
// (R01) low reset input resets the processor
// (R02) clock held off while reset low
// (R03) hang-up low on watchdog or stack fault
// (R04) low-voltage detect also drives hang-up low
// (R05) external interrupt input sampled as request
// (R06) counter width 11, 12 or 13 bits
// (R07) counter cleared to zero on reset
// (R08) counter addresses sixteen-bit program memory
// (R09) code, vectors, tables share fetch path
// (R10) branches and table reads reach all memory
// (R11) direct call limited to 0000H..07FFH
// (R12) calls and interrupts push return address
// (R13) hang-up low when pointer six or more
// (R14) eight-value pointer, down push, up pop
// (R15) counter increments unless loaded
// (R16) hang-up fed back resets like external
`timescale 1ns/1ps
`default_nettype none
module pcrh_core (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// variant and supervision
	input wire logic [1:0] variant_i,
	input wire logic wdt_overflow_i,
	input wire logic lvd_fitted_i,
	input wire logic lvd_low_i,
	input wire logic hang_feedback_i,
	// sequencing requests
	input wire logic fetch_i,
	input wire pcrh_pkg::pcrh_op_t op_i,
	input wire logic [pcrh_pkg::PC_W-1:0] target_i,
	input wire logic table_first_i,
	input wire logic table_second_i,
	input wire logic [pcrh_pkg::PC_W-1:0] addr_reg_i,
	// interrupts
	input wire logic ext_int_i,
	input wire logic int_accept_i,
	input wire logic [pcrh_pkg::PC_W-1:0] int_vector_i,
	// program memory
	output logic [pcrh_pkg::PC_W-1:0] rom_addr_o,
	output logic [pcrh_pkg::PC_W-1:0] prog_counter_o,
	output logic [pcrh_pkg::SP_W-1:0] stack_level_ptr_o,
	output logic [pcrh_pkg::PC_W-1:0] return_addr_o,
	output logic int_req_o,
	output logic save_sys_o,
	output logic clk_run_o,
	// hang-up open-drain pin
	output logic hang_up_out_n_o,
	output logic hang_up_out_n_oe_o
);
	import pcrh_pkg::*;

	typedef struct packed {
		logic [PC_W-1:0] pc;
		logic int_req;
		logic save_sys;
		logic wdt_hit;
	} pcrh_state_t;

	pcrh_state_t st_q, st_d;
	logic sys_rst_b;
	logic push, pop, stk_hang;
	logic [PC_W-1:0] stk_top;
	logic [PC_W-1:0] pc_mask;

	// mask the counter to the variant's memory size
	function automatic logic [PC_W-1:0] rom_end(input logic [1:0] v);
		case (v)
			VAR_2K: rom_end = ROM_END_2K;
			VAR_4K: rom_end = ROM_END_4K;
			VAR_6K: rom_end = ROM_END_6K;
			default: rom_end = ROM_END_8K;
		endcase
	endfunction

	// both reset sources merge; feedback assumed already synchronous
	assign sys_rst_b = rst_b_i && hang_feedback_i; // R01 R16
	assign clk_run_o = sys_rst_b; // R02
	assign pc_mask = (variant_i == VAR_2K) ? 13'h07FF : (variant_i == VAR_4K) ? 13'h0FFF : 13'h1FFF; // R06

	// push on call, push, table first cycle, accepted interrupt
	always_comb begin
		push = int_accept_i || table_first_i; // R12
		pop = table_second_i;
		if (fetch_i && !int_accept_i) begin
			case (op_i)
				PCRH_OP_CALL_DIR, PCRH_OP_CALL_IND, PCRH_OP_PUSH: push = 1'b1; // R12 R14
				PCRH_OP_RET, PCRH_OP_POP: pop = 1'b1; // R14
				default: ;
			endcase
		end
	end

	pcrh_stack u_stack (
		.clk_i(clk_i),
		.rst_b_i(sys_rst_b),
		.push_i(push),
		.pop_i(pop),
		.push_data_i((op_i == PCRH_OP_PUSH && !int_accept_i && !table_first_i) ? addr_reg_i : st_q.pc),
		.top_o(stk_top),
		.ptr_o(stack_level_ptr_o),
		.hang_o(stk_hang)
	);

	// next program counter value
	always_comb begin
		st_d = st_q;
		st_d.int_req = ext_int_i; // R05
		st_d.save_sys = int_accept_i; // R12
		st_d.wdt_hit = st_q.wdt_hit | wdt_overflow_i; // R03
		if (int_accept_i) begin
			st_d.pc = int_vector_i & pc_mask;
		end else if (fetch_i) begin
			case (op_i)
				PCRH_OP_BRANCH: st_d.pc = target_i & pc_mask; // R10
				PCRH_OP_CALL_DIR: st_d.pc = target_i & CALL_LIMIT; // R11
				PCRH_OP_CALL_IND: st_d.pc = addr_reg_i & pc_mask; // R10
				PCRH_OP_RET: st_d.pc = stk_top & pc_mask;
				default: st_d.pc = (st_q.pc + 13'h0001) & pc_mask; // R15
			endcase
		end
		if (st_d.pc > rom_end(variant_i)) begin
			st_d.pc = PC_RESET; // R08
		end
	end

	always_ff @(posedge clk_i or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			st_q <= '0; // R07
		end else begin
			st_q <= st_d;
		end
	end

	// table reads use the address register through the same fetch path
	assign rom_addr_o = table_second_i ? (addr_reg_i & pc_mask) : st_q.pc; // R09
	assign prog_counter_o = st_q.pc;
	assign return_addr_o = stk_top;
	assign int_req_o = st_q.int_req;
	assign save_sys_o = st_q.save_sys;
	// open drain: drive low only, release otherwise
	assign hang_up_out_n_o = 1'b0;
	assign hang_up_out_n_oe_o = st_q.wdt_hit || stk_hang || (lvd_fitted_i && lvd_low_i); // R03 R04 R13

	// no disable here: reset itself is the antecedent
	property p_reset_pc;
		@(posedge clk_i)
		!sys_rst_b |=> (prog_counter_o == PC_RESET);
	endproperty
	a_reset_pc: assert property (p_reset_pc) else $error("pc not cleared"); // R07

	property p_call_limit;
		@(posedge clk_i) disable iff (!sys_rst_b)
		(fetch_i && !int_accept_i && op_i == PCRH_OP_CALL_DIR) |=> (prog_counter_o <= 13'h07FF);
	endproperty
	a_call_limit: assert property (p_call_limit) else $error("direct call beyond limit"); // R11

	property p_step;
		@(posedge clk_i) disable iff (!sys_rst_b)
		(fetch_i && !int_accept_i && op_i == PCRH_OP_NEXT && prog_counter_o < (pc_mask & rom_end(variant_i)))
		|=> (prog_counter_o == $past(prog_counter_o) + 13'h0001);
	endproperty
	a_step: assert property (p_step) else $error("pc did not advance"); // R15

	property p_wdt_hang;
		@(posedge clk_i) disable iff (!sys_rst_b)
		wdt_overflow_i |=> hang_up_out_n_oe_o;
	endproperty
	a_wdt_hang: assert property (p_wdt_hang) else $error("watchdog did not pull hang-up"); // R03

	property p_lvd;
		@(posedge clk_i) disable iff (!sys_rst_b)
		(lvd_fitted_i && lvd_low_i) |-> hang_up_out_n_oe_o;
	endproperty
	a_lvd: assert property (p_lvd) else $error("low voltage not flagged"); // R04

	property p_int_sample;
		@(posedge clk_i) disable iff (!sys_rst_b)
		ext_int_i |=> int_req_o;
	endproperty
	a_int_sample: assert property (p_int_sample) else $error("interrupt not sampled"); // R05

	sequence s_accept;
		int_accept_i;
	endsequence
	property p_int_push;
		@(posedge clk_i) disable iff (!sys_rst_b)
		s_accept ##0 (stack_level_ptr_o < 3'h5) ##1 1'b1 |-> save_sys_o && return_addr_o == $past(prog_counter_o);
	endproperty
	a_int_push: assert property (p_int_push) else $error("interrupt return address lost"); // R12

	property p_width;
		@(posedge clk_i) disable iff (!sys_rst_b)
		prog_counter_o <= rom_end(variant_i);
	endproperty
	a_width: assert property (p_width) else $error("pc beyond variant memory"); // R06 R08

	property p_stack_hang;
		@(posedge clk_i) disable iff (!sys_rst_b)
		(stack_level_ptr_o >= SP_HANG_MIN) |-> hang_up_out_n_oe_o;
	endproperty
	a_stack_hang: assert property (p_stack_hang) else $error("stack fault did not pull hang-up"); // R13
endmodule
`default_nettype wire

// >>> pcrh_pkg.sv
`default_nettype none
package pcrh_pkg;
	// program counter width for the largest variant; the 2K and 4K variants mask high bits
	localparam int PC_W = 13;
	localparam int SP_W = 3;
	localparam int STK_DEPTH = 5;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] CALL_LIMIT = 13'h07FF;
	localparam logic [SP_W-1:0] SP_RESET = 3'h5;
	localparam logic [SP_W-1:0] SP_HANG_MIN = 3'h6;
	// variant program memory ends
	localparam logic [PC_W-1:0] ROM_END_2K = 13'h07FF;
	localparam logic [PC_W-1:0] ROM_END_4K = 13'h0FFF;
	localparam logic [PC_W-1:0] ROM_END_6K = 13'h17FF;
	localparam logic [PC_W-1:0] ROM_END_8K = 13'h1FFF;
	// sequencing operations
	typedef enum logic [6:0] {
		PCRH_OP_NEXT = 7'h01,
		PCRH_OP_BRANCH = 7'h02,
		PCRH_OP_CALL_DIR = 7'h04,
		PCRH_OP_CALL_IND = 7'h08,
		PCRH_OP_RET = 7'h10,
		PCRH_OP_PUSH = 7'h20,
		PCRH_OP_POP = 7'h40
	} pcrh_op_t;
	// variant selection codes
	localparam logic [1:0] VAR_2K = 2'h0;
	localparam logic [1:0] VAR_4K = 2'h1;
	localparam logic [1:0] VAR_6K = 2'h2;
	localparam logic [1:0] VAR_8K = 2'h3;
endpackage
`default_nettype wire

// >>> pcrh_stack.sv
`timescale 1ns/1ps
`default_nettype none
module pcrh_stack (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// stack operations
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [pcrh_pkg::PC_W-1:0] push_data_i,
	// state
	output logic [pcrh_pkg::PC_W-1:0] top_o,
	output logic [pcrh_pkg::SP_W-1:0] ptr_o,
	output logic hang_o
);
	import pcrh_pkg::*;

	typedef struct packed {
		logic [SP_W-1:0] ptr;
		logic [STK_DEPTH-1:0][PC_W-1:0] mem;
	} pcrh_stk_t;

	pcrh_stk_t s_q, s_d;
	logic [SP_W-1:0] dec_ptr;

	// push decrements first then writes; wrap of 0 to 7 is the overflow case
	always_comb begin
		s_d = s_q;
		dec_ptr = s_q.ptr - 3'h1;
		if (push_i && !pop_i) begin
			s_d.ptr = dec_ptr; // R14
			if (dec_ptr < 3'(STK_DEPTH)) begin
				s_d.mem[dec_ptr] = push_data_i; // R12
			end
		end else if (pop_i && !push_i) begin
			s_d.ptr = s_q.ptr + 3'h1; // R14
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.ptr <= SP_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// slots 5..7 do not exist; reading them returns zero
	assign top_o = (s_q.ptr < 3'(STK_DEPTH)) ? s_q.mem[s_q.ptr] : '0;
	assign ptr_o = s_q.ptr;
	assign hang_o = (s_q.ptr >= SP_HANG_MIN); // R13

	// hang must flag exactly the two pointer values beyond the empty value 5
	property p_hang_ptr;
		@(posedge clk_i) disable iff (!rst_b_i)
		hang_o == (ptr_o == 3'h6 || ptr_o == 3'h7);
	endproperty
	a_hang_ptr: assert property (p_hang_ptr) else $error("hang flag disagrees with pointer"); // R13

	property p_push_dec;
		@(posedge clk_i) disable iff (!rst_b_i)
		(push_i && !pop_i) |=> (ptr_o == $past(ptr_o) - 3'h1);
	endproperty
	a_push_dec: assert property (p_push_dec) else $error("push did not decrement"); // R14

	property p_pop_inc;
		@(posedge clk_i) disable iff (!rst_b_i)
		(pop_i && !push_i) |=> (ptr_o == $past(ptr_o) + 3'h1);
	endproperty
	a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment"); // R14
endmodule
`default_nettype wire

// >>> pcrh_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pcrh_partner (
	// bench controls
	input wire logic rst_req_b_i,
	input wire logic strap_i,
	input wire logic irq_i,
	// device side
	input wire logic hang_oe_i,
	output logic rst_b_o,
	output logic hang_fb_o,
	output logic ext_int_o
);
	// reset button; the strap is the wire from hang-up back to reset
	assign rst_b_o = rst_req_b_i;
	// pull-up holds the line high once the pin lets go
	assign hang_fb_o = strap_i ? ~hang_oe_i : 1'b1;
	assign ext_int_o = irq_i;
endmodule
`default_nettype wire

// >>> test_program_counter_reset_hangup.sv
`timescale 1ns/1ps
`default_nettype none
module test_program_counter_reset_hangup;
	import pcrh_pkg::*;
	logic clk_i, rq_b, strap, irq, fetch, wdt, lfit, llow, acc, rst_b, fb, xint, ireq, save, run, hn, oe;
	logic [1:0] var_q;
	pcrh_op_t op;
	logic [PC_W-1:0] tgt, vec, rom, pc, ret;
	logic tf, ts;
	logic [PC_W-1:0] areg;
	logic [SP_W-1:0] ptr;
	int error_cnt = 0;
	int check_count = 0;
	logic [PC_W-1:0] ends [4] = '{ROM_END_2K, ROM_END_4K, ROM_END_6K, ROM_END_8K};
	pcrh_partner u_partner (.rst_req_b_i(rq_b), .strap_i(strap), .irq_i(irq), .hang_oe_i(oe),
		.rst_b_o(rst_b), .hang_fb_o(fb), .ext_int_o(xint));
	pcrh_core u_dut (.clk_i(clk_i), .rst_b_i(rst_b), .variant_i(var_q), .wdt_overflow_i(wdt),
		.lvd_fitted_i(lfit), .lvd_low_i(llow), .hang_feedback_i(fb), .fetch_i(fetch), .op_i(op),
		.target_i(tgt), .table_first_i(tf), .table_second_i(ts), .addr_reg_i(areg),
		.ext_int_i(xint), .int_accept_i(acc), .int_vector_i(vec), .rom_addr_o(rom), .prog_counter_o(pc),
		.stack_level_ptr_o(ptr), .return_addr_o(ret), .int_req_o(ireq), .save_sys_o(save),
		.clk_run_o(run), .hang_up_out_n_o(hn), .hang_up_out_n_oe_o(oe));
	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [PC_W-1:0] seen, input logic [PC_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one step; sampled 1 ns after the edge that takes it lands
	task automatic step(input pcrh_op_t o, input logic [PC_W-1:0] t);
		@(posedge clk_i);
		fetch <= 1'b1;
		op <= o;
		tgt <= t;
		@(posedge clk_i);
		fetch <= 1'b0;
		#1;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rq_b <= 1'b0;
		tick(16);
		check(PC_W'(run), 13'h0000);
		check(pc, PC_RESET);
		@(posedge clk_i);
		rq_b <= 1'b1;
		tick(1);
	endtask
	task automatic t_call();
		do_reset();
		check(PC_W'(ptr), PC_W'(SP_RESET));
		check(PC_W'(oe), 13'h0000);
		check(PC_W'(hn), 13'h0000);
		step(PCRH_OP_NEXT, 13'h0000);
		step(PCRH_OP_NEXT, 13'h0000);
		check(rom, 13'h0002);
		step(PCRH_OP_CALL_DIR, 13'h0900);
		check(pc, 13'h0100);
		check(PC_W'(ptr), 13'h0004);
		check(ret, 13'h0002);
		step(PCRH_OP_RET, 13'h0000);
		check(pc, 13'h0002);
		$display("call test done");
	endtask
	task automatic t_wrap();
		for (int v = 0; v < 4; v++) begin
			@(posedge clk_i);
			var_q <= 2'(v);
			step(PCRH_OP_BRANCH, ends[v]);
			check(pc, ends[v]);
			step(PCRH_OP_NEXT, 13'h0000);
			check(rom, PC_RESET);
		end
		$display("wrap test done");
	endtask
	task automatic t_stack();
		step(PCRH_OP_POP, 13'h0000);
		check(PC_W'(ptr), PC_W'(SP_HANG_MIN));
		check(PC_W'(oe), 13'h0001);
		do_reset();
		repeat (6) step(PCRH_OP_PUSH, 13'h0000);
		check(PC_W'(ptr), 13'h0007);
		check(PC_W'(oe), 13'h0001);
		$display("stack test done");
	endtask
	// watchdog latch, then low supply with and without the strap
	task automatic t_sup();
		do_reset();
		@(posedge clk_i);
		wdt <= 1'b1;
		@(posedge clk_i);
		wdt <= 1'b0;
		tick(3);
		check(PC_W'(oe), 13'h0001);
		do_reset();
		@(posedge clk_i);
		llow <= 1'b1;
		tick(1);
		check(PC_W'(oe), 13'h0000);
		@(posedge clk_i);
		lfit <= 1'b1;
		step(PCRH_OP_NEXT, 13'h0000);
		check(PC_W'(oe), 13'h0001);
		@(posedge clk_i);
		strap <= 1'b1;
		tick(2);
		check(PC_W'(run), 13'h0000);
		check(pc, PC_RESET);
		@(posedge clk_i);
		llow <= 1'b0;
		tick(2);
		check(PC_W'(run), 13'h0001);
		$display("supervision test done");
	endtask
	task automatic t_int();
		step(PCRH_OP_BRANCH, 13'h0155);
		@(posedge clk_i);
		irq <= 1'b1;
		tick(2);
		check(PC_W'(ireq), 13'h0001);
		@(posedge clk_i);
		acc <= 1'b1;
		vec <= 13'h0040;
		@(posedge clk_i);
		acc <= 1'b0;
		#1;
		check(pc, 13'h0040);
		check(PC_W'(ptr), 13'h0004);
		check(PC_W'(save), 13'h0001);
		check(ret, 13'h0155);
		$display("interrupt test done");
	endtask
	// table read pushes then pops, fetching through the address register; indirect call
	task automatic t_table();
		do_reset();
		step(PCRH_OP_BRANCH, 13'h1123);
		check(pc, 13'h1123);
		@(posedge clk_i);
		tf <= 1'b1;
		areg <= 13'h1ABC;
		@(posedge clk_i);
		tf <= 1'b0;
		ts <= 1'b1;
		#1;
		check(PC_W'(ptr), 13'h0004);
		check(ret, 13'h1123);
		check(rom, 13'h1ABC);
		@(posedge clk_i);
		ts <= 1'b0;
		#1;
		check(PC_W'(ptr), PC_W'(SP_RESET));
		check(rom, 13'h1123);
		step(PCRH_OP_CALL_IND, 13'h0000);
		check(pc, 13'h1ABC);
		check(ret, 13'h1123);
		step(PCRH_OP_RET, 13'h0000);
		check(pc, 13'h1123);
		$display("table test done");
	endtask
	// start in reset with every input defined
	initial begin
		{rq_b, strap, irq, fetch, wdt, lfit, llow, acc, tf, ts} = 10'h000;
		areg = 13'h0000;
		var_q = VAR_8K;
		op = PCRH_OP_NEXT;
		tgt = 13'h0000;
		vec = 13'h0000;
		t_call();
		t_wrap();
		t_stack();
		t_sup();
		t_int();
		t_table();
		report_and_stop();
	end
	// hang guard, far beyond the 170 or so cycles the tests need
	initial begin
		#50000;
		error_cnt++;
		report_and_stop();
	end
endmodule
`default_nettype wire
